// File: verilog/fhp_port.sv
// Host parallel port of a buffered flash device: address latching,
// writes, async and burst reads, ready, done signal, die select.
// Assumes the core answers a read address with data one cycle later.
`timescale 1ns/1ps

// Functional notes
// - Host address selects buffer memory or register location, read or write.
// - Data bus released when deselected or outputs disabled.
// - Host drives commands and write data; device drives only reads.
// - Done signal reports completion of a previously issued command.
// - Done pin floats until drive enable set, then always driven.
// - Burst valid marks read data, driven only while selected.
// - Burst start address latched at each host clock rise with strobe low; the last such rise wins.
// - Async reads capture address at address strobe rising edge.
// - Address inputs ignored while address strobe is high.
// - Writes take data bus value at write strobe rising edge.
// - Reset pin low resets internal operation.
// - Reset pin ignored during power-up and boot loading.
// - Select low activates logic; high means standby, bus released.
// - Quad stack: each select enables one dual-die pair.
// - Output drivers enabled during reads only while output enable low.
module fhp_port
    import fhp_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rstn_i,
    // Host pins
    input  wire logic [ADDR_W-1:0] host_address_bus_i,
    input  wire logic [DATA_W-1:0] host_data_bus_i,
    output logic      [DATA_W-1:0] host_data_bus_o,
    output logic                   host_data_bus_oe_o,
    input  wire logic              address_valid_strobe_n_i,
    input  wire logic              write_strobe_n_i,
    input  wire logic              output_drive_enable_n_i,
    input  wire logic              first_die_select_n_i,
    input  wire logic              second_die_select_n_i,
    input  wire logic              host_clk_i,
    input  wire logic              reset_in_n_i,
    output logic                   burst_data_valid_o,
    output logic                   burst_data_valid_oe_o,
    output logic                   command_done_signal_o,
    output logic                   command_done_signal_oe_o,
    // Core side
    input  wire logic [1:0]        die_cfg_i,
    input  wire logic              sync_mode_i,
    input  wire logic [LAT_W-1:0]  read_latency_i,
    input  wire logic              int_pin_drive_enable_i,
    input  wire logic              boot_busy_i,
    input  wire logic              core_cmd_done_i,
    input  wire logic [DATA_W-1:0] core_rdata_i,
    output fhp_core_req_t          core_req_o,
    output logic                   core_reset_o,
    output logic [1:0]             die_pair_sel_o
);

    // =========================================
    // Pin synchronisation
    // =========================================
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s;

    assign pin_raw = {reset_in_n_i,
                      host_clk_i,
                      second_die_select_n_i,
                      first_die_select_n_i,
                      output_drive_enable_n_i,
                      write_strobe_n_i,
                      address_valid_strobe_n_i,
                      host_data_bus_i,
                      host_address_bus_i};

    fhp_sync
    #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    )
    u_sync
    (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   (pin_raw),
        .sync_o    (pin_s)
    );

    // =========================================
    // Decoded pin levels and edges
    // =========================================
    logic [CTL_W-1:0]  ctl_prev_reg;
    wire  [CTL_W-1:0]  ctl_now  = pin_s[CTL_LO +: CTL_W];
    wire  [ADDR_W-1:0] addr_s   = pin_s[SY_ADDR +: ADDR_W];
    wire  [DATA_W-1:0] data_s   = pin_s[SY_DATA +: DATA_W];
    wire               avd_n    = pin_s[SY_AVD_N];
    wire               we_n     = pin_s[SY_WE_N];
    wire               oe_n     = pin_s[SY_OE_N];
    wire               ce1_n    = pin_s[SY_CE1_N];
    wire               ce2_n    = pin_s[SY_CE2_N];
    wire               rst_n    = pin_s[SY_RST_N];

    wire avd_rise = avd_n & ~ctl_prev_reg[SY_AVD_N - CTL_LO];
    wire we_rise  = we_n  & ~ctl_prev_reg[SY_WE_N  - CTL_LO];
    wire clk_rise = pin_s[SY_CLK] & ~ctl_prev_reg[SY_CLK - CTL_LO];

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
            ctl_prev_reg <= CTL_RST;
        else
            ctl_prev_reg <= ctl_now;
    end

    // =========================================
    // Die configuration strap
    // =========================================
    fhp_die_cfg_t die_cfg_reg;
    logic         strap_done_reg;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            die_cfg_reg    <= FHP_DIE_SINGLE;
            strap_done_reg <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            die_cfg_reg    <= fhp_die_cfg_t'(die_cfg_i);
            strap_done_reg <= 1'b1;
        end
    end

    // Quad stack: either select wakes its own pair
    wire is_quad  = (die_cfg_reg == FHP_DIE_QUAD);
    wire pair1_on = ~ce1_n;
    wire pair2_on = is_quad & ~ce2_n;
    wire selected = pair1_on | pair2_on;

    // =========================================
    // Operation reset
    // =========================================
    // Pin is don't care while the core is booting
    wire op_reset = ~rst_n & ~boot_busy_i;

    // =========================================
    // Burst read sequencer
    // =========================================
    fhp_burst_t        bs_reg;
    fhp_burst_t        bs_next;
    logic [LAT_W-1:0]  lat_cnt_reg;
    logic [LAT_W-1:0]  lat_cnt_next;
    logic [ADDR_W-1:0] burst_addr_reg;
    logic [ADDR_W-1:0] burst_addr_next;

    wire burst_go  = sync_mode_i & selected & clk_rise & ~avd_n;
    wire lat_last  = (lat_cnt_reg <= LAT_ONE);

    always_comb
    begin
        bs_next         = bs_reg;
        lat_cnt_next    = lat_cnt_reg;
        burst_addr_next = burst_addr_reg;
        case (bs_reg)
            FHP_BS_IDLE:
            begin
                if (burst_go)
                begin
                    bs_next         = FHP_BS_WAIT;
                    lat_cnt_next    = read_latency_i;
                    burst_addr_next = addr_s;
                end
            end
            FHP_BS_WAIT:
            begin
                if (clk_rise)
                begin
                    if (lat_last)
                        bs_next = FHP_BS_DATA;
                    else
                        lat_cnt_next = lat_cnt_reg - LAT_ONE;
                end
            end
            FHP_BS_DATA:
            begin
                if (clk_rise)
                    burst_addr_next = burst_addr_reg + ADDR_ONE;
            end
            default:
            begin
                bs_next = FHP_BS_IDLE;
            end
        endcase
        // New start strobe restarts the burst
        if (bs_reg != FHP_BS_IDLE && burst_go)
        begin
            bs_next         = FHP_BS_WAIT;
            lat_cnt_next    = read_latency_i;
            burst_addr_next = addr_s;
        end
        if (!selected || !sync_mode_i)
            bs_next = FHP_BS_IDLE;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i || op_reset)
        begin
            bs_reg         <= FHP_BS_IDLE;
            lat_cnt_reg    <= LAT_RST;
            burst_addr_reg <= ADDR_RST;
        end
        else
        begin
            bs_reg         <= bs_next;
            lat_cnt_reg    <= lat_cnt_next;
            burst_addr_reg <= burst_addr_next;
        end
    end

    // =========================================
    // Asynchronous address latch
    // =========================================
    logic [ADDR_W-1:0] async_addr_reg;

    // Address is only looked at while the strobe is low
    wire avd_track = ~avd_n & ~sync_mode_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i || op_reset)
            async_addr_reg <= ADDR_RST;
        else if (avd_track)
            async_addr_reg <= addr_s;
        else if (avd_rise && !sync_mode_i)
            async_addr_reg <= async_addr_reg;
    end

    wire [ADDR_W-1:0] async_addr = avd_track ? addr_s
                                             : async_addr_reg;

    // =========================================
    // Host writes and core requests
    // =========================================
    wire              wr_take  = we_rise & selected & ~op_reset;
    wire [ADDR_W-1:0] rd_addr  = sync_mode_i ? burst_addr_next
                                             : async_addr;
    wire [ADDR_W-1:0] wr_addr  = ~avd_n ? addr_s
                                        : async_addr_reg;

    fhp_core_req_t req_next;

    always_comb
    begin
        req_next       = REQ_RST;
        req_next.addr  = rd_addr;
        if (wr_take)
        begin
            req_next.valid = 1'b1;
            req_next.write = 1'b1;
            req_next.addr  = wr_addr;
            req_next.wdata = data_s;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
            core_req_o <= REQ_RST;
        else
            core_req_o <= req_next;
    end

    // =========================================
    // Data bus drivers
    // =========================================
    // Read cycle: selected, outputs on, no write strobe
    wire rd_cycle  = selected & ~oe_n & we_n;
    wire sync_hold = sync_mode_i & (bs_reg != FHP_BS_DATA);
    wire dq_drive  = rd_cycle & ~sync_hold & ~op_reset;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            host_data_bus_o    <= DATA_RST;
            host_data_bus_oe_o <= 1'b0;
        end
        else
        begin
            host_data_bus_o    <= core_rdata_i;
            host_data_bus_oe_o <= dq_drive;
        end
    end

    // =========================================
    // Burst valid output
    // =========================================
    wire rdy_level = sync_mode_i ? (bs_reg == FHP_BS_DATA) : 1'b1;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            burst_data_valid_o    <= 1'b0;
            burst_data_valid_oe_o <= 1'b0;
        end
        else
        begin
            burst_data_valid_o    <= rdy_level & selected;
            burst_data_valid_oe_o <= selected;
        end
    end

    // =========================================
    // Command done output
    // =========================================
    logic drive_en_reg;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
            drive_en_reg <= 1'b0;
        else if (int_pin_drive_enable_i)
            drive_en_reg <= 1'b1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            command_done_signal_o    <= 1'b0;
            command_done_signal_oe_o <= 1'b0;
        end
        else
        begin
            command_done_signal_o    <= core_cmd_done_i;
            command_done_signal_oe_o <= drive_en_reg
                                      | int_pin_drive_enable_i;
        end
    end

    // =========================================
    // Core reset and die pair select
    // =========================================
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            core_reset_o   <= 1'b1;
            die_pair_sel_o <= 2'b00;
        end
        else
        begin
            core_reset_o   <= op_reset;
            die_pair_sel_o <= {pair2_on, pair1_on};
        end
    end

endmodule // fhp_port

// File: verilog/fhp_pkg.sv
// Constants and types for the flash host parallel port.
// Assumes pins arrive unsynchronised and are sampled on sys_clk_i.
package fhp_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LAT_W  = 3;

    // =========================================
    // Synchroniser vector layout
    // =========================================
    localparam int SYNC_W    = 39;
    localparam int SY_ADDR   = 0;
    localparam int SY_DATA   = 16;
    localparam int SY_AVD_N  = 32;
    localparam int SY_WE_N   = 33;
    localparam int SY_OE_N   = 34;
    localparam int SY_CE1_N  = 35;
    localparam int SY_CE2_N  = 36;
    localparam int SY_CLK    = 37;
    localparam int SY_RST_N  = 38;
    localparam int CTL_LO    = 32;
    localparam int CTL_W     = 7;
    // Strobes idle high, clock low
    localparam logic [SYNC_W-1:0] SYNC_RST = 39'h5F_0000_0000;
    localparam logic [CTL_W-1:0]  CTL_RST  = 7'h5F;

    // =========================================
    // Reset values
    // =========================================
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [LAT_W-1:0]  LAT_RST  = 3'h0;
    localparam logic [LAT_W-1:0]  LAT_ONE  = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;

    typedef enum logic [1:0]
    {
        FHP_DIE_SINGLE,
        FHP_DIE_DUAL,
        FHP_DIE_QUAD
    } fhp_die_cfg_t;

    typedef enum
    {
        FHP_BS_IDLE,
        FHP_BS_WAIT,
        FHP_BS_DATA
    } fhp_burst_t;

    // Request toward buffer memory and register space
    typedef struct packed
    {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fhp_core_req_t;

    localparam fhp_core_req_t REQ_RST = '{1'b0, 1'b0, 16'h0000, 16'h0000};

endpackage

// File: verilog/fhp_sync.sv
// Two-stage synchroniser, one per bit.
// Assumes synchronous active-low reset on the sampling clock.
`timescale 1ns/1ps
module fhp_sync
#(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
)
(
    input  wire logic           sys_clk_i,
    input  wire logic           rstn_i,
    input  wire logic [W-1:0]   async_i,
    output logic      [W-1:0]   sync_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // =========================================
    // Per-bit flop pair
    // =========================================
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge sys_clk_i)
            begin
                if (!rstn_i)
                begin
                    meta_reg[g] <= RST_VAL[g];
                    sync_reg[g] <= RST_VAL[g];
                end
                else
                begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_reg;

endmodule // fhp_sync

// File: test/fhp_port_monitor.sv
// Checker for the host parallel port, on top-level ports only.
// Assumes host pins hold each phase for at least four clocks.
`timescale 1ns/1ps
module fhp_port_monitor
    import fhp_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [DATA_W-1:0] host_data_bus_i,
    input  wire logic              host_data_bus_oe_o,
    input  wire logic              address_valid_strobe_n_i,
    input  wire logic              write_strobe_n_i,
    input  wire logic              output_drive_enable_n_i,
    input  wire logic              first_die_select_n_i,
    input  wire logic              second_die_select_n_i,
    input  wire logic              reset_in_n_i,
    input  wire logic              burst_data_valid_o,
    input  wire logic              burst_data_valid_oe_o,
    input  wire logic              command_done_signal_o,
    input  wire logic              command_done_signal_oe_o,
    input  wire logic [1:0]        die_cfg_i,
    input  wire logic              sync_mode_i,
    input  wire logic              boot_busy_i,
    input  wire logic              core_cmd_done_i,
    input  wire fhp_core_req_t     core_req_o,
    input  wire logic              core_reset_o,
    input  wire logic [1:0]        die_pair_sel_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ========
    // Deselect run length
    logic       desel;
    logic [2:0] desel_reg;
    assign desel = first_die_select_n_i
                 && (second_die_select_n_i || die_cfg_i != 2'h2);
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i || !desel)
            desel_reg <= 3'h0;
        else if (desel_reg != 3'h7)
            desel_reg <= desel_reg + 3'h1;
    end

    // ========
    // Properties
    desel_release_a: assert property (
        desel_reg >= 3'h5 |-> !host_data_bus_oe_o && !burst_data_valid_oe_o)
        else $error("Bus or ready driven while deselected");
    oe_gate_a: assert property (
        output_drive_enable_n_i [*4] |-> !host_data_bus_oe_o)
        else $error("Data driven with output enable high");
    we_gate_a: assert property (
        !write_strobe_n_i [*4] |-> !host_data_bus_oe_o)
        else $error("Data driven during write strobe");
    done_stick_a: assert property (
        command_done_signal_oe_o |=> command_done_signal_oe_o)
        else $error("Done pin released after enable");
    done_follow_a: assert property (
        core_cmd_done_i [*2] |-> command_done_signal_o)
        else $error("Done pin missed completion");
    write_only_a: assert property (
        core_req_o.valid |-> core_req_o.write && $past(write_strobe_n_i, 2))
        else $error("Request without write strobe rise");
    wdata_take_a: assert property (
        core_req_o.valid |-> core_req_o.wdata == $past(host_data_bus_i, 3))
        else $error("Write data not taken at strobe rise");
    desel_nowrite_a: assert property (
        desel_reg >= 3'h6 |-> !core_req_o.valid)
        else $error("Write while deselected");
    pin_reset_a: assert property (
        (!reset_in_n_i && !boot_busy_i) [*5] |-> core_reset_o)
        else $error("Reset pin not honoured");
    boot_ignore_a: assert property (
        boot_busy_i [*5] |-> !core_reset_o)
        else $error("Reset pin acted during boot load");
    quad_pair_a: assert property (
        (die_cfg_i == 2'h2 && first_die_select_n_i
         && !second_die_select_n_i) [*5] |-> die_pair_sel_o == 2'h2)
        else $error("Second pair not selected");
    addr_hold_a: assert property (
        (address_valid_strobe_n_i && !sync_mode_i && reset_in_n_i) [*5]
        |-> $stable(core_req_o.addr))
        else $error("Address moved while strobe high");

    cover property (core_req_o.valid);
    cover property ($rose(burst_data_valid_o) && burst_data_valid_oe_o);
    cover property ($rose(command_done_signal_oe_o));
endmodule // fhp_port_monitor

bind fhp_port fhp_port_monitor u_monitor
(
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .host_data_bus_i(host_data_bus_i),
    .host_data_bus_oe_o(host_data_bus_oe_o),
    .address_valid_strobe_n_i(address_valid_strobe_n_i),
    .write_strobe_n_i(write_strobe_n_i),
    .output_drive_enable_n_i(output_drive_enable_n_i),
    .first_die_select_n_i(first_die_select_n_i),
    .second_die_select_n_i(second_die_select_n_i),
    .reset_in_n_i(reset_in_n_i),
    .burst_data_valid_o(burst_data_valid_o),
    .burst_data_valid_oe_o(burst_data_valid_oe_o),
    .command_done_signal_o(command_done_signal_o),
    .command_done_signal_oe_o(command_done_signal_oe_o),
    .die_cfg_i(die_cfg_i), .sync_mode_i(sync_mode_i),
    .boot_busy_i(boot_busy_i), .core_cmd_done_i(core_cmd_done_i),
    .core_req_o(core_req_o), .core_reset_o(core_reset_o),
    .die_pair_sel_o(die_pair_sel_o)
);

// File: test/fhp_host_model.sv
// Host bus model driving the parallel port pins from bench tasks.
// Assumes one task at a time; pins move at falling clock edges.
`timescale 1ns/1ps
module fhp_host_model
    import fhp_pkg::*;
(
    input  wire logic              sys_clk_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] data_o,
    output logic                   avd_n_o,
    output logic                   we_n_o,
    output logic                   oe_n_o,
    output logic                   cs1_n_o,
    output logic                   cs2_n_o,
    output logic                   hclk_o
);
    initial
    begin
        {addr_o, data_o} = 32'h0000_FFFF;
        {avd_n_o, we_n_o, oe_n_o, cs1_n_o, cs2_n_o} = 5'h1F;
        hclk_o = 1'b0;
    end

    // ========
    // Pin tasks
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic pins(input logic s1, input logic s2, input logic oe);
        @(negedge sys_clk_i);
        {cs1_n_o, cs2_n_o, oe_n_o} = {s1, s2, oe};
    endtask

    // Pins scrambled once the strobe is high
    task automatic latch_addr(input logic [ADDR_W-1:0] a);
        @(negedge sys_clk_i);
        addr_o = a;
        avd_n_o = 1'b0;
        idle(4);
        avd_n_o = 1'b1;
        idle(3);
        addr_o = ~a;
    endtask

    task automatic write_word(input logic [ADDR_W-1:0] a,
                              input logic [DATA_W-1:0] d);
        latch_addr(a);
        data_o = d;
        we_n_o = 1'b0;
        idle(4);
        we_n_o = 1'b1;
        idle(4);
        data_o = ~d;
    endtask

    // 80 ns host clock, still between frames
    task automatic hclk_cycle();
        hclk_o = 1'b1;
        idle(4);
        hclk_o = 1'b0;
        idle(4);
    endtask

    task automatic burst_start(input logic [ADDR_W-1:0] a);
        @(negedge sys_clk_i);
        addr_o = a;
        avd_n_o = 1'b0;
        idle(2);
        hclk_cycle();
        avd_n_o = 1'b1;
        addr_o = ~a;
    endtask
endmodule // fhp_host_model

// File: test/flash_host_parallel_port_bench.sv
// Self-checking bench for the host port with a host bus model.
// Assumes a core store answering one cycle after an address.
`timescale 1ns/1ps
module flash_host_parallel_port_bench
    import fhp_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              rst_pin_n = 1'b1;
    logic [1:0]        die_cfg = 2'h0;
    logic              sync_mode = 1'b0;
    logic [LAT_W-1:0]  lat = 3'h4;
    logic              drv_en = 1'b0;
    logic              en_seen = 1'b0;
    logic              boot_busy = 1'b0;
    logic              cmd_done = 1'b0;
    logic [DATA_W-1:0] rdata = 16'h0000;
    logic [DATA_W-1:0] wr_count = 16'h0000;
    logic [DATA_W-1:0] h_data, dq, prev, d;
    logic [ADDR_W-1:0] h_addr, a;
    logic              h_avd_n, h_we_n, h_oe_n, h_cs1_n, h_cs2_n, h_clk;
    logic              dq_oe, rdy, rdy_oe, done, done_oe, core_rst;
    logic [1:0]        pair;
    wire  [DATA_W-1:0] bus_lvl;
    fhp_core_req_t     req, last_req;
    int                num_errors = 0, checks = 0, seed = 32'h6440;

    always #5 sys_clk = ~sys_clk;
    assign bus_lvl = dq_oe ? dq : h_data;

    fhp_host_model host
    (
        .sys_clk_i(sys_clk), .addr_o(h_addr), .data_o(h_data),
        .avd_n_o(h_avd_n), .we_n_o(h_we_n), .oe_n_o(h_oe_n),
        .cs1_n_o(h_cs1_n), .cs2_n_o(h_cs2_n), .hclk_o(h_clk)
    );

    fhp_port dut
    (
        .sys_clk_i(sys_clk), .rstn_i(rstn),
        .host_address_bus_i(h_addr), .host_data_bus_i(bus_lvl),
        .host_data_bus_o(dq), .host_data_bus_oe_o(dq_oe),
        .address_valid_strobe_n_i(h_avd_n), .write_strobe_n_i(h_we_n),
        .output_drive_enable_n_i(h_oe_n),
        .first_die_select_n_i(h_cs1_n), .second_die_select_n_i(h_cs2_n),
        .host_clk_i(h_clk), .reset_in_n_i(rst_pin_n),
        .burst_data_valid_o(rdy), .burst_data_valid_oe_o(rdy_oe),
        .command_done_signal_o(done), .command_done_signal_oe_o(done_oe),
        .die_cfg_i(die_cfg), .sync_mode_i(sync_mode), .read_latency_i(lat),
        .int_pin_drive_enable_i(drv_en), .boot_busy_i(boot_busy),
        .core_cmd_done_i(cmd_done), .core_rdata_i(rdata),
        .core_req_o(req), .core_reset_o(core_rst), .die_pair_sel_o(pair)
    );

    // ========
    // Core store and write log
    function automatic logic [15:0] mem_word(input logic [15:0] x);
        return x ^ 16'hA5C3;
    endfunction

    always @(posedge sys_clk)
    begin
        rdata <= mem_word(req.addr);
        if (req.valid === 1'b1)
        begin
            last_req <= req;
            wr_count <= wr_count + 16'h0001;
        end
    end

    // ========
    // Checks and verdict
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        check16({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic complete_run();
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] cfg);
        rstn = 1'b0;
        die_cfg = cfg;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
    endtask

    initial
    begin
        #400000;
        num_errors++;
        complete_run();
    end

    // ========
    // Scenarios
    initial
    begin
        do_reset(2'($random(seed)) & 2'h1);
        @(negedge sys_clk);
        {boot_busy, rst_pin_n} = 2'b10;
        host.idle(8);
        check1(core_rst, 1'b0);
        boot_busy = 1'b0;
        host.idle(8);
        check1(core_rst, 1'b1);
        prev = wr_count;
        host.pins(1'b0, 1'b1, 1'b1);
        host.write_word(16'h0010, 16'h1234);
        check16(wr_count, prev);
        rst_pin_n = 1'b1;
        host.idle(8);
        check1(core_rst, 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            rst_pin_n = 1'b1;
            host.idle(3);
            boot_busy = 1'($random(seed));
            rst_pin_n = ~boot_busy | 1'($random(seed));
            a = (k == 0) ? 16'hFFFF : 16'($random(seed));
            d = (k == 1) ? 16'h0000 : 16'($random(seed));
            prev = wr_count;
            host.write_word(a, d);
            check16(wr_count, prev + 16'h0001);
            check16(last_req.addr, a);
            check16(last_req.wdata, d);
        end
        rst_pin_n = 1'b1;
        host.pins(1'b1, 1'b1, 1'b0);
        prev = wr_count;
        host.write_word(16'h0055, 16'hAAAA);
        check16(wr_count, prev);
        check1(dq_oe, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            a = 16'($random(seed));
            host.pins(1'b0, 1'b1, 1'b1);
            host.latch_addr(a);
            host.pins(1'b0, 1'b1, 1'b0);
            host.idle(8);
            check16(dq, mem_word(a));
            check1(dq_oe, 1'b1);
            host.pins(1'b0, 1'b1, 1'b1);
            host.idle(6);
            check1(dq_oe, 1'b0);
        end
        sync_mode = 1'b1;
        for (int l = 3; l <= 4; l++)
        begin
            lat = 3'(l);
            host.pins(1'b0, 1'b1, 1'b0);
            a = 16'($random(seed));
            host.burst_start(a);
            for (int r = 1; r <= 6; r++)
            begin
                host.hclk_cycle();
                check1(rdy, 1'(r >= l));
                d = (r == l) ? a : mem_word(prev) + 16'h0001;
                if (r >= l)
                    check16(mem_word(dq), d);
                prev = dq;
            end
            check1(rdy_oe, 1'b1);
            host.pins(1'b1, 1'b1, 1'b1);
            host.idle(6);
            check1(rdy_oe, 1'b0);
        end
        sync_mode = 1'b0;
        check1(done_oe, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            cmd_done = 1'($random(seed));
            drv_en = (k == 4) | 1'($random(seed));
            host.idle(2);
            check1(done, cmd_done);
            en_seen = en_seen | drv_en;
            check1(done_oe, en_seen);
        end
        drv_en = 1'b0;
        host.idle(4);
        check1(done_oe, 1'b1);
        cmd_done = ~cmd_done;
        host.idle(2);
        check1(done, cmd_done);
        do_reset(2'h2);
        check1(done_oe, 1'b0);
        host.pins(1'b1, 1'b0, 1'b1);
        host.idle(6);
        check16({14'h0000, pair}, 16'h0002);
        prev = wr_count;
        host.write_word(16'h0123, 16'h4567);
        check16(wr_count, prev + 16'h0001);
        complete_run();
    end
endmodule // flash_host_parallel_port_bench
